// ---- inc/pdm_pkg.sv ----
package pdm_pkg;
	// Power modes of the controller
	typedef enum {
		PDM_RUN,
		PDM_SLEEP,
		PDM_SW_STANDBY,
		PDM_SETTLE,
		PDM_HW_STANDBY,
		PDM_RESET_HOLD
	} pdm_state_t;

	// System control register field positions and width
	localparam int SCR_W = 8;
	localparam int SEL_POS = 7;
	localparam int SETTLE_LSB = 4;
	localparam int SETTLE_SEL_W = 3;
	// Reset value of the system control register
	localparam logic [7:0] SCR_RESET = 8'h0B;

	// Settle counts in states, one state per clock
	localparam int SETTLE_BASE = 8192;
	localparam int SETTLE_MAX = 131072;
	localparam int SETTLE_W = 18;

	// Wake-up requests as one carrier
	typedef struct packed {
		logic nmi;      // Non-maskable request
		logic line0;    // External line 0 request
		logic line1;    // External line 1 request
		logic line2;    // External line 2 request
		logic strobe;   // Input strobe request
		logic maskable; // Any enabled maskable request
	} pdm_wake_t;

	// Gating outputs as one carrier
	typedef struct packed {
		logic osc_run;      // Oscillator enable
		logic cpu_clk_en;   // CPU clock gate
		logic mod_clk_en;   // Supporting-module clock gate
		logic mod_init;     // Hold modules in initial state
		logic cpu_reset;    // CPU reset (registers lost or reset sequence)
		logic port_hiz;     // Ports to high impedance
	} pdm_gate_t;
endpackage : pdm_pkg

// ---- logic/pdm_power_down_mode_control.sv ----
module pdm_power_down_mode_control #(
	parameter int SETTLE_BASE_P = pdm_pkg::SETTLE_BASE
) (
	// Clock, reset, enable
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// External pins
	input wire logic hw_standby_pin_n_in,
	input wire logic hard_init_pin_n_in,
	// CPU side
	input wire logic sleep_exec_in,
	input wire logic cpu_int_mask_in,
	input wire logic scr_we_in,
	input wire logic [7:0] scr_wdata_in,
	input wire pdm_pkg::pdm_wake_t wake_in,
	// Outputs
	output pdm_pkg::pdm_gate_t gate_out,
	output logic [7:0] system_control_reg_out,
	output logic int_service_out,
	output logic [2:0] mode_out
);
	// The longest code shifts the base left by four, so the counter
	// must hold sixteen times the base or the top code would wrap
	initial begin
		if (SETTLE_BASE_P < 1 || SETTLE_BASE_P * 16 >= (1 << pdm_pkg::SETTLE_W))
			$error("SETTLE_BASE_P does not fit the settle counter");
	end

	pdm_pkg::pdm_state_t state, next_state;
	logic [7:0] system_control_reg;  // Register mirror kept here
	logic mask_at_sleep;              // CPU mask latched as sleep begins
	logic [pdm_pkg::SETTLE_W-1:0] settle_cnt;
	pdm_pkg::pdm_gate_t next_gate;

	// Decode settle count from the field
	// A shift of the base keeps the decode small; every code with the
	// top bit set shares the longest wait
	function automatic logic [pdm_pkg::SETTLE_W-1:0] settle_len(input logic [2:0] sel);
		logic [pdm_pkg::SETTLE_W-1:0] base;
		base = pdm_pkg::SETTLE_W'(SETTLE_BASE_P);
		if (sel[2])
			settle_len = base << 4;
		else
			settle_len = base << sel[1:0];
	endfunction : settle_len

	// Field views
	wire standby_select_bit = system_control_reg[pdm_pkg::SEL_POS];
	wire [2:0] settle_time_sel = system_control_reg[pdm_pkg::SETTLE_LSB +: pdm_pkg::SETTLE_SEL_W];
	// Standby wake sources ignore the CPU mask
	wire ext_wake = wake_in.nmi | wake_in.line0 | wake_in.line1 | wake_in.line2 | wake_in.strobe;
	// Sleep wake: masked CPU only listens to NMI; disabled modules never assert maskable
	wire sleep_wake = wake_in.nmi | (~mask_at_sleep & wake_in.maskable);
	wire settle_done = settle_cnt == '0;
	wire hw_standby = ~hw_standby_pin_n_in;
	wire init_low = ~hard_init_pin_n_in;

	// Mode transitions; standby pin outranks everything, reset next
	// Pins are levels, so a pin held low keeps pulling the mode back
	// each cycle; no edge detector is needed and none can misfire
	// after reset
	always_comb begin
		next_state = state;
		if (hw_standby) begin
			next_state = pdm_pkg::PDM_HW_STANDBY;
		end else begin
			unique case (state)
				pdm_pkg::PDM_RUN: begin
					if (init_low)
						next_state = pdm_pkg::PDM_RESET_HOLD;
					else if (sleep_exec_in && standby_select_bit)
						next_state = pdm_pkg::PDM_SW_STANDBY;
					else if (sleep_exec_in)
						next_state = pdm_pkg::PDM_SLEEP;
				end
				pdm_pkg::PDM_SLEEP: begin
					if (init_low)
						next_state = pdm_pkg::PDM_RESET_HOLD;
					else if (sleep_wake)
						next_state = pdm_pkg::PDM_RUN;
				end
				pdm_pkg::PDM_SW_STANDBY: begin
					if (init_low)
						next_state = pdm_pkg::PDM_RESET_HOLD;
					else if (ext_wake)
						next_state = pdm_pkg::PDM_SETTLE;
				end
				pdm_pkg::PDM_SETTLE: begin
					if (init_low)
						next_state = pdm_pkg::PDM_RESET_HOLD;
					else if (settle_done)
						next_state = pdm_pkg::PDM_RUN;
				end
				// Leave only once the pin is high and reset then rises
				pdm_pkg::PDM_HW_STANDBY: begin
					if (init_low)
						next_state = pdm_pkg::PDM_RESET_HOLD;
				end
				pdm_pkg::PDM_RESET_HOLD: begin
					if (!init_low)
						next_state = pdm_pkg::PDM_RUN;
				end
			endcase
		end
	end

	// Gating per mode
	// Decoded from the next mode so the registered gates change on
	// the same edge as the mode they belong to
	always_comb begin
		next_gate = '0;
		unique case (next_state)
			pdm_pkg::PDM_RUN: begin
				next_gate.osc_run = 1'b1;
				next_gate.cpu_clk_en = 1'b1;
				next_gate.mod_clk_en = 1'b1;
			end
			// CPU halted, clock and modules keep running
			pdm_pkg::PDM_SLEEP: begin
				next_gate.osc_run = 1'b1;
				next_gate.mod_clk_en = 1'b1;
			end
			// Clock stopped, modules initialized, CPU and ports held
			pdm_pkg::PDM_SW_STANDBY: begin
				next_gate.mod_init = 1'b1;
			end
			// Oscillator running, pulses withheld
			pdm_pkg::PDM_SETTLE: begin
				next_gate.osc_run = 1'b1;
				next_gate.mod_init = 1'b1;
			end
			// RAM kept, CPU lost, modules initialized, ports floated
			pdm_pkg::PDM_HW_STANDBY: begin
				next_gate.mod_init = 1'b1;
				next_gate.cpu_reset = 1'b1;
				next_gate.port_hiz = 1'b1;
			end
			// Oscillator starts while reset is low
			pdm_pkg::PDM_RESET_HOLD: begin
				next_gate.osc_run = 1'b1;
				next_gate.mod_init = 1'b1;
				next_gate.cpu_reset = 1'b1;
				next_gate.port_hiz = hw_standby;
			end
		endcase
	end

	// State, gates and service pulse
	// A low clock enable freezes every register here; the reset
	// branch still wins so a frozen block can be cleared
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			state <= pdm_pkg::PDM_RUN;
			gate_out <= '0;
			int_service_out <= 1'b0;
			mode_out <= '0;
		end else if (clk_en_in) begin
			state <= next_state;
			gate_out <= next_gate;
			// Interrupt handling follows a settled or sleep wake
			int_service_out <= (state == pdm_pkg::PDM_SETTLE || state == pdm_pkg::PDM_SLEEP)
				&& next_state == pdm_pkg::PDM_RUN;
			mode_out <= 3'(next_state);
		end
	end

	// Settle counter loads in every standby cycle, counts down in settle
	// Loading on every standby cycle means a field change made just
	// before the instruction is always honoured; the count ends at
	// zero and then rests there
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			settle_cnt <= '0;
		end else if (clk_en_in) begin
			if (state == pdm_pkg::PDM_SW_STANDBY)
				settle_cnt <= settle_len(settle_time_sel) - 1'b1;
			else if (!settle_done)
				settle_cnt <= settle_cnt - 1'b1;
		end
	end

	// CPU mask captured with the power-down instruction
	// Later mask changes cannot reach the halted CPU, so the value at
	// entry is the one that decides
	always_ff @(posedge clock_in) begin
		if (!rst_n_in)
			mask_at_sleep <= 1'b0;
		else if (clk_en_in && state == pdm_pkg::PDM_RUN && sleep_exec_in)
			mask_at_sleep <= cpu_int_mask_in;
	end

	// Register: reset sequence reloads its reset value; interrupt wake leaves the select bit alone
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			system_control_reg <= pdm_pkg::SCR_RESET;
		end else if (clk_en_in) begin
			// Held reset clears the select bit; writes are refused
			// outside run because the CPU is halted then
			if (state == pdm_pkg::PDM_RESET_HOLD || state == pdm_pkg::PDM_HW_STANDBY)
				system_control_reg <= pdm_pkg::SCR_RESET;
			else if (scr_we_in && state == pdm_pkg::PDM_RUN)
				system_control_reg <= scr_wdata_in;
		end
	end

	// Register view from a flip-flop
	// The view lags the register by one cycle; software that writes
	// and reads back at once sees the old value
	always_ff @(posedge clock_in) begin
		if (!rst_n_in)
			system_control_reg_out <= pdm_pkg::SCR_RESET;
		else if (clk_en_in)
			system_control_reg_out <= system_control_reg;
	end
endmodule : pdm_power_down_mode_control

// ---- bench/pdm_power_down_mode_control_asserts.sv ----
module pdm_asserts (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// Inputs watched
	input wire logic hw_standby_pin_n_in,
	input wire logic hard_init_pin_n_in,
	input wire logic sleep_exec_in,
	input wire pdm_pkg::pdm_wake_t wake_in,
	// Outputs watched
	input wire pdm_pkg::pdm_gate_t gate_out,
	input wire logic [7:0] system_control_reg_out,
	input wire logic int_service_out,
	input wire logic [2:0] mode_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	// Clean instruction in run, pins idle
	wire logic go_w = mode_out == 3'h0 && sleep_exec_in && clk_en_in && hw_standby_pin_n_in && hard_init_pin_n_in;
	// Settle count ends in run
	sequence settle_end_s; mode_out == 3'h3 ##1 mode_out == 3'h0; endsequence
	// Two enabled cycles that start in reset hold
	sequence hold_two_s; mode_out == 3'h5 && clk_en_in ##1 clk_en_in; endsequence
	sleep_entry_a: assert property (go_w && !system_control_reg_out[7] |=> mode_out == 3'h1
		&& gate_out.osc_run && !gate_out.cpu_clk_en && gate_out.mod_clk_en) else $error("sleep entry wrong");
	soft_entry_a: assert property (go_w && system_control_reg_out[7] |=> mode_out == 3'h2
		&& gate_out == 6'b000100) else $error("standby entry wrong");
	hard_entry_a: assert property (!hw_standby_pin_n_in && clk_en_in |=> mode_out == 3'h4
		&& gate_out.port_hiz && !gate_out.osc_run) else $error("pin standby wrong");
	hard_exit_a: assert property (mode_out == 3'h4 |=> mode_out inside {3'h4, 3'h5})
		else $error("pin standby left early");
	soft_hold_a: assert property (mode_out == 3'h2 && wake_in[5:1] == 5'h00 && clk_en_in
		&& hw_standby_pin_n_in && hard_init_pin_n_in |=> mode_out == 3'h2) else $error("standby left without cause");
	settle_gate_a: assert property (mode_out == 3'h3 |-> gate_out.osc_run && !gate_out.cpu_clk_en
		&& !gate_out.mod_clk_en) else $error("clock leaked in settle");
	wake_service_a: assert property (settle_end_s |-> int_service_out && system_control_reg_out[7])
		else $error("no service after settle");
	hold_clear_a: assert property (hold_two_s |=> system_control_reg_out == 8'h0B)
		else $error("reset hold wrong");
	hold_osc_a: assert property (mode_out == 3'h5 |-> gate_out.osc_run)
		else $error("oscillator off in reset hold");
	freeze_hold_a: assert property (!clk_en_in |=> $stable(mode_out) && $stable(gate_out)
		&& $stable(int_service_out)) else $error("outputs moved while frozen");
endmodule : pdm_asserts

bind pdm_power_down_mode_control pdm_asserts chk_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
	.clk_en_in(clk_en_in), .hw_standby_pin_n_in(hw_standby_pin_n_in), .hard_init_pin_n_in(hard_init_pin_n_in),
	.sleep_exec_in(sleep_exec_in), .wake_in(wake_in), .gate_out(gate_out),
	.system_control_reg_out(system_control_reg_out), .int_service_out(int_service_out), .mode_out(mode_out));

// ---- bench/pdm_cpu_model.sv ----
module pdm_cpu_model (
	// Clock
	input wire logic clock_in,
	// CPU and interrupt side
	output logic sleep_exec_out,
	output logic cpu_int_mask_out,
	output logic scr_we_out,
	output logic [7:0] scr_wdata_out,
	output pdm_pkg::pdm_wake_t wake_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle at time zero
	initial begin
		{sleep_exec_out, cpu_int_mask_out, scr_we_out, scr_wdata_out, wake_out} = '0;
	end
	// One-cycle instruction pulse, mask sampled with it
	task automatic sleep_op(input logic m);
		@(negedge clock_in);
		cpu_int_mask_out = m;
		sleep_exec_out = 1'b1;
		@(negedge clock_in);
		sleep_exec_out = 1'b0;
	endtask : sleep_op
	// Write, then wait out the lagging copy
	task automatic write_reg(input logic [7:0] v);
		@(negedge clock_in);
		scr_wdata_out = v;
		scr_we_out = 1'b1;
		@(negedge clock_in);
		scr_we_out = 1'b0;
		repeat (2) @(negedge clock_in);
	endtask : write_reg
	// Request levels change at the caller's falling edge
	task automatic set_wake(input logic [5:0] w);
		wake_out = w;
	endtask : set_wake
endmodule : pdm_cpu_model

// ---- bench/pdm_power_down_mode_control_tb_top.sv ----
module pdm_power_down_mode_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_in = 1'b0, rst_n_in = 1'b0, hw_standby_pin_n = 1'b1, hard_init_pin_n = 1'b1, clk_en = 1'b1;
	logic sleep_exec, mask, we, svc;
	logic [7:0] wdata, sreg;
	logic [2:0] mode;
	pdm_pkg::pdm_wake_t wake;
	pdm_pkg::pdm_gate_t gate;
	int bad_count = 0, check_count = 0, cyc = 0;
	always #50 clock_in = ~clock_in;
	// Short settle base keeps the run small
	pdm_power_down_mode_control #(.SETTLE_BASE_P(4)) dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.clk_en_in(clk_en), .hw_standby_pin_n_in(hw_standby_pin_n), .hard_init_pin_n_in(hard_init_pin_n),
		.sleep_exec_in(sleep_exec), .cpu_int_mask_in(mask), .scr_we_in(we), .scr_wdata_in(wdata),
		.wake_in(wake), .gate_out(gate), .system_control_reg_out(sreg), .int_service_out(svc), .mode_out(mode));
	pdm_cpu_model cpu_u (.clock_in(clock_in), .sleep_exec_out(sleep_exec), .cpu_int_mask_out(mask),
		.scr_we_out(we), .scr_wdata_out(wdata), .wake_out(wake));
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Bounded wait, then compare the mode
	task automatic wait_mode(input logic [2:0] m);
		for (int n = 0; n < 200 && mode !== m; n++) @(negedge clock_in);
		chk({5'h00, mode}, {5'h00, m});
	endtask : wait_mode
	task automatic test_sleep;
		cpu_u.write_reg(8'h0B);
		cpu_u.sleep_op(1'b0);
		wait_mode(3'h1);
		chk({2'b00, gate}, 8'h28);
		cpu_u.set_wake(6'h01);
		wait_mode(3'h0);
		cpu_u.set_wake(6'h00);
		cpu_u.sleep_op(1'b1);
		cpu_u.set_wake(6'h01);
		repeat (4) @(negedge clock_in);
		chk({5'h00, mode}, 8'h01);
		cpu_u.set_wake(6'h20);
		wait_mode(3'h0);
		cpu_u.set_wake(6'h00);
		$display("test_sleep done");
	endtask : test_sleep
	// Settle codes 0 to 4 and 7, woken in turn by NMI, lines 0 to 2, strobe, then NMI again
	task automatic test_soft;
		logic [2:0] sel;
		int n;
		for (int i = 0; i < 6; i++) begin
			sel = (i == 5) ? 3'h7 : 3'(i);
			cpu_u.write_reg({1'b1, sel, 4'hB});
			cpu_u.sleep_op(1'b0);
			wait_mode(3'h2);
			chk({2'b00, gate}, 8'h04);
			cpu_u.set_wake(6'h20 >> (i % 5));
			wait_mode(3'h3);
			cpu_u.set_wake(6'h00);
			for (n = 0; mode === 3'h3 && n < 100; n++) @(negedge clock_in);
			chk(8'(n), sel[2] ? 8'h40 : 8'h04 << sel);
			chk({7'h00, svc}, 8'h01);
			@(negedge clock_in);
			chk(sreg, {1'b1, sel, 4'hB});
		end
		$display("test_soft done");
	endtask : test_soft
	task automatic test_pins;
		cpu_u.sleep_op(1'b0);
		wait_mode(3'h2);
		hard_init_pin_n = 1'b0;
		wait_mode(3'h5);
		chk({7'h00, gate.osc_run}, 8'h01);
		repeat (3) @(negedge clock_in);
		chk(sreg, 8'h0B);
		hard_init_pin_n = 1'b1;
		wait_mode(3'h0);
		@(negedge clock_in);
		chk(sreg, 8'h0B);
		hw_standby_pin_n = 1'b0;
		wait_mode(3'h4);
		chk({7'h00, gate.port_hiz}, 8'h01);
		hard_init_pin_n = 1'b0;
		hw_standby_pin_n = 1'b1;
		wait_mode(3'h5);
		hard_init_pin_n = 1'b1;
		wait_mode(3'h0);
		$display("test_pins done");
	endtask : test_pins
	// Low clock enable: a pulse and a wake are both held off
	task automatic test_freeze;
		clk_en = 1'b0;
		cpu_u.sleep_op(1'b0);
		repeat (2) @(negedge clock_in);
		chk({5'h00, mode}, 8'h00);
		chk({2'b00, gate}, 8'h38);
		clk_en = 1'b1;
		cpu_u.sleep_op(1'b0);
		wait_mode(3'h1);
		clk_en = 1'b0;
		cpu_u.set_wake(6'h20);
		repeat (3) @(negedge clock_in);
		chk({5'h00, mode}, 8'h01);
		clk_en = 1'b1;
		wait_mode(3'h0);
		cpu_u.set_wake(6'h00);
		$display("test_freeze done");
	endtask : test_freeze
	// Hang guard well above the expected run
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			finish_test();
		end
	end
	initial begin
		repeat (12) @(negedge clock_in);
		rst_n_in = 1'b1;
		repeat (2) @(negedge clock_in);
		test_sleep();
		test_soft();
		test_pins();
		test_freeze();
		finish_test();
	end
endmodule : pdm_power_down_mode_control_tb_top
